// ---- shared/loop_port_pkg.sv ----
// constants for the loop converter holding register port
package loop_port_pkg;
  localparam int          WORD_W      = 10;
  localparam int          LO_W        = 8;
  localparam int          HI_W        = 2;
  localparam int          LO_LSB      = 0;
  localparam int          HI_LSB      = 8;
  localparam logic [9:0]  WORD_MAX    = 10'h3FF;
  localparam logic [9:0]  WORD_MIN    = 10'h000;
  localparam logic [9:0]  WORD_RESET  = 10'h000;
  localparam int          CLK_HZ      = 25000000;
  // slow step clock for increment/decrement
  localparam int          STEP_HZ     = 2000;
  localparam int          STEP_CYC    = CLK_HZ / STEP_HZ;
  localparam int          STEP_W      = 18;
  // carrier free-run rate and sync loss window
  localparam int          CARRIER_HZ  = 200000;
  localparam int          HALF_CYC    = CLK_HZ / (2 * CARRIER_HZ);
  localparam int          LOSS_CYC    = 4 * HALF_CYC;
  localparam int          CAR_W       = 8;
endpackage : loop_port_pkg

// ---- src/step_divider.sv ----
// divider producing one-cycle step enables while stepping is active
`timescale 1ns/1ps
module step_divider #(
  parameter int unsigned PERIOD = 250000
) (
  input  wire logic clk,    // system clock
  input  wire logic rst,    // sync reset, active high
  input  wire logic run,    // count while high
  output logic      tick    // one-cycle step enable
);
  logic [loop_port_pkg::STEP_W-1:0] cnt_reg;
  logic [loop_port_pkg::STEP_W-1:0] cnt_next;
  logic                             tick_next;

  // restart on each run so the first step comes a full period after the command
  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!run) begin
      cnt_next = '0;
    end else if (cnt_reg == loop_port_pkg::STEP_W'(PERIOD - 1)) begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + loop_port_pkg::STEP_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick    <= tick_next;
    end
  end

  step_period_a: assert property (@(posedge clk) disable iff (rst)
    tick |=> !tick)
    else $error("step tick lasted more than one cycle");
endmodule : step_divider

// ---- src/loop_port.sv ----
// parallel host port: split holding register, readback, up/down counter, carrier
`timescale 1ns/1ps
// Functional notes
// - a 10-bit holding register, loaded by host write controls, holds the code.
// - lower 8 and upper 2 bits have separate load and output enables.
// - readback drives the bus only while a read control is high.
// - holding register also counts up or down on step commands.
// - an internal slow clock paces counter steps during stepping.
// - stepping past either end never wraps to the opposite extreme.
// - carrier follows external sync, free-runs when sync is lost.
// - the held word is presented continuously to the converter.
module loop_port (
  input  wire logic       clk,       // 25 MHz clock
  input  wire logic       rst,       // sync reset, active high
  input  wire logic [9:0] data_in,   // bus data into the port
  output logic      [9:0] data_out,  // readback data
  output logic      [9:0] data_oe,   // readback enables per bit
  input  wire logic       wr_lo,     // load lower 8 bits
  input  wire logic       wr_hi,     // load upper 2 bits
  input  wire logic       rd_lo,     // read lower 8 bits
  input  wire logic       rd_hi,     // read upper 2 bits
  input  wire logic       clear,     // clear held word
  input  wire logic       step_up,   // increment while high
  input  wire logic       step_down, // decrement while high
  input  wire logic       sync_in,   // external carrier sync
  output logic            carrier,   // carrier clock out
  output logic            synced,    // high while following sync
  output logic      [9:0] dac_code   // word to the converter
);
  logic [9:0] word_reg;
  logic [9:0] word_next;
  logic       tick;
  logic       stepping;
  logic       any_wr;

  assign any_wr   = wr_lo | wr_hi | clear;
  // both step lines together cancel out rather than jitter
  assign stepping = (step_up ^ step_down) & !any_wr;

  step_divider #(
    .PERIOD (loop_port_pkg::STEP_CYC)
  ) u_step (
    .clk  (clk),
    .rst  (rst),
    .run  (stepping),
    .tick (tick)
  );

  // limit decode kept apart so both ends are refused the same way
  function automatic logic step_refused(
    input logic [9:0] word, // held word
    input logic       up,   // increment requested
    input logic       down  // decrement requested
  );
    step_refused = (up && word == loop_port_pkg::WORD_MAX) ||
                   (down && word == loop_port_pkg::WORD_MIN);
  endfunction : step_refused

  always_comb begin
    word_next = word_reg;
    if (clear) begin
      word_next = loop_port_pkg::WORD_RESET;
    end else if (any_wr) begin
      if (wr_lo) begin
        word_next[loop_port_pkg::HI_LSB-1:loop_port_pkg::LO_LSB] = data_in[7:0];
      end
      if (wr_hi) begin
        word_next[loop_port_pkg::WORD_W-1:loop_port_pkg::HI_LSB] = data_in[9:8];
      end
    end else if (tick && stepping && !step_refused(word_reg, step_up, step_down)) begin
      if (step_up) begin
        word_next = word_reg + 10'h001;
      end else begin
        word_next = word_reg - 10'h001;
      end
    end
  end

  // readback
  logic [9:0] oe_next;
  always_comb begin
    oe_next = {{loop_port_pkg::HI_W{rd_hi}}, {loop_port_pkg::LO_W{rd_lo}}};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      word_reg <= loop_port_pkg::WORD_RESET;
      data_out <= 10'h000;
    end else begin
      word_reg <= word_next;
      data_out <= word_next;
    end
  end

  assign data_oe  = oe_next;
  assign dac_code = word_reg;

  clear_zero_a: assert property (@(posedge clk) disable iff (rst)
    clear |=> word_reg == loop_port_pkg::WORD_RESET)
    else $error("clear did not zero the held word");

  hi_load_a: assert property (@(posedge clk) disable iff (rst)
    (wr_hi && !clear) |=> word_reg[loop_port_pkg::WORD_W-1:loop_port_pkg::HI_LSB] ==
      $past(data_in[loop_port_pkg::WORD_W-1:loop_port_pkg::HI_LSB]))
    else $error("upper part not loaded");

  lo_keep_a: assert property (@(posedge clk) disable iff (rst)
    (wr_hi && !wr_lo && !clear) |=>
      word_reg[loop_port_pkg::HI_LSB-1:loop_port_pkg::LO_LSB] ==
      $past(word_reg[loop_port_pkg::HI_LSB-1:loop_port_pkg::LO_LSB]))
    else $error("lower part disturbed by upper write");

  step_inc_a: assert property (@(posedge clk) disable iff (rst)
    (tick && stepping && step_up && word_reg != loop_port_pkg::WORD_MAX) |=>
      word_reg == $past(word_reg) + 10'h001)
    else $error("increment step missing");

  step_dec_a: assert property (@(posedge clk) disable iff (rst)
    (tick && stepping && step_down && word_reg != loop_port_pkg::WORD_MIN) |=>
      word_reg == $past(word_reg) - 10'h001)
    else $error("decrement step missing");

  // carrier: free-run divider, restarted by sync edges while sync is live
  logic             sync_d_reg;
  logic [7:0]       div_reg;
  logic [7:0]       div_next;
  logic [7:0]       loss_reg;
  logic [7:0]       loss_next;
  logic             car_reg;
  logic             car_next;
  logic             sync_edge;
  logic             live;

  assign sync_edge = sync_in & !sync_d_reg;
  assign live      = loss_reg != 8'h00;

  always_comb begin
    div_next  = div_reg;
    car_next  = car_reg;
    loss_next = loss_reg;
    if (sync_edge) begin
      loss_next = loop_port_pkg::CAR_W'(loop_port_pkg::LOSS_CYC);
      div_next  = 8'h00;
      car_next  = 1'b1;
    end else begin
      if (live) begin
        loss_next = loss_reg - 8'h01;
      end
      if (live && !sync_in && car_reg) begin // follow falling half of sync
        car_next = 1'b0;
        div_next = 8'h00;
      end else if (!live && div_reg == loop_port_pkg::CAR_W'(loop_port_pkg::HALF_CYC - 1)) begin
        div_next = 8'h00; // free run
        car_next = !car_reg;
      end else if (!live) begin
        div_next = div_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_d_reg <= 1'b0;
      div_reg    <= 8'h00;
      loss_reg   <= 8'h00;
      car_reg    <= 1'b0;
    end else begin
      sync_d_reg <= sync_in;
      div_reg    <= div_next;
      loss_reg   <= loss_next;
      car_reg    <= car_next;
    end
  end

  assign carrier = car_reg;
  assign synced  = live;

  sync_rise_a: assert property (@(posedge clk) disable iff (rst)
    sync_edge |=> carrier && synced)
    else $error("carrier did not lock to sync edge");

  sync_fall_a: assert property (@(posedge clk) disable iff (rst)
    (live && !sync_edge && !sync_in && carrier) |=> !carrier)
    else $error("carrier did not follow sync low");

  sync_loss_a: assert property (@(posedge clk) disable iff (rst)
    (live && !sync_edge) |=> loss_reg == $past(loss_reg) - 8'h01)
    else $error("sync loss window not counting");

  top_lock_a: assert property (@(posedge clk) disable iff (rst)
    (word_reg == loop_port_pkg::WORD_MAX && !any_wr && !step_down) |=>
      word_reg == loop_port_pkg::WORD_MAX)
    else $error("count wrapped past top");

  bottom_lock_a: assert property (@(posedge clk) disable iff (rst)
    (word_reg == loop_port_pkg::WORD_MIN && !any_wr && !step_up) |=>
      word_reg == loop_port_pkg::WORD_MIN)
    else $error("count wrapped past bottom");

  lo_load_a: assert property (@(posedge clk) disable iff (rst)
    (wr_lo && !clear) |=> word_reg[7:0] == $past(data_in[7:0]))
    else $error("lower part not loaded");

  hi_keep_a: assert property (@(posedge clk) disable iff (rst)
    (wr_lo && !wr_hi && !clear) |=> word_reg[9:8] == $past(word_reg[9:8]))
    else $error("upper part disturbed by lower write");

  read_gate_a: assert property (@(posedge clk) disable iff (rst)
    data_oe == {{loop_port_pkg::HI_W{rd_hi}}, {loop_port_pkg::LO_W{rd_lo}}})
    else $error("readback enable mismatch");

  step_only_a: assert property (@(posedge clk) disable iff (rst)
    (!any_wr && !tick) |=> $stable(word_reg))
    else $error("word changed without command");

  dac_track_a: assert property (@(posedge clk) disable iff (rst)
    dac_code == word_reg)
    else $error("converter code differs from held word");

  free_run_a: assert property (@(posedge clk) disable iff (rst)
    (!live && !sync_edge && div_reg == loop_port_pkg::CAR_W'(loop_port_pkg::HALF_CYC - 1)) |=>
      carrier != $past(carrier))
    else $error("free-running carrier did not toggle");
endmodule : loop_port

// ---- tb/host_model.sv ----
// host bus model: resolves the shared data wire against readback
`timescale 1ns/1ps
module host_model (
  input  wire logic [9:0] data_out, // port readback
  input  wire logic [9:0] data_oe,  // port drive enables
  input  wire logic [9:0] host_val, // last value the host drove
  output logic      [9:0] bus       // resolved wire level
);
  // released bits show the inverse so a stale value cannot pass
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      bus[i] = data_oe[i] ? data_out[i] : ~host_val[i];
    end
  end
endmodule : host_model

// ---- tb/testbench.sv ----
// self-checking bench for the holding register port
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD %0t mismatch %h vs %h", $time, a, b); end end
module testbench;
  logic       clk = 0, rst = 1, wr_lo = 0, wr_hi = 0, rd_lo = 0, rd_hi = 0;
  logic       clear = 0, step_up = 0, step_down = 0, sync_in = 0;
  logic [9:0] data_in = 10'h000, data_out, data_oe, dac_code, bus;
  logic       carrier, synced;
  int         n_errors = 0, num_checks = 0;
  loop_port dut_u (.clk(clk), .rst(rst), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .wr_lo(wr_lo), .wr_hi(wr_hi), .rd_lo(rd_lo), .rd_hi(rd_hi),
    .clear(clear), .step_up(step_up), .step_down(step_down), .sync_in(sync_in),
    .carrier(carrier), .synced(synced), .dac_code(dac_code));
  host_model host_u (.data_out(data_out), .data_oe(data_oe), .host_val(data_in),
    .bus(bus));
  initial begin
    forever #20 clk = ~clk;
  end
  task test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task wr(input logic lo, input logic hi, input logic [9:0] d);
    @(negedge clk) begin wr_lo = lo; wr_hi = hi; data_in = d; end
    @(negedge clk) begin wr_lo = 0; wr_hi = 0; end
  endtask : wr
  task rd(input logic lo, input logic hi, input logic [9:0] oe, input logic [9:0] v);
    @(negedge clk) begin rd_lo = lo; rd_hi = hi; end
    #1 `CHK(data_oe, oe)
    `CHK(bus & oe, v & oe)
    @(negedge clk) begin rd_lo = 0; rd_hi = 0; end
  endtask : rd
  task split_access;
    wr(1, 0, 10'h0AB);
    `CHK(dac_code, 10'h0AB)
    wr(0, 1, 10'h355);
    `CHK(dac_code, 10'h3AB)
    rd(1, 0, 10'h0FF, 10'h3AB);
    rd(0, 1, 10'h300, 10'h3AB);
    rd(0, 0, 10'h000, 10'h000);
    wr(1, 1, 10'h155);
    `CHK(dac_code, 10'h155)
    rd(1, 1, 10'h3FF, 10'h155);
  endtask : split_access
  task step_run(input logic up, input logic [9:0] start, input logic [9:0] last);
    wr(1, 1, start);
    step_up = up;
    step_down = ~up;
    repeat (loop_port_pkg::STEP_CYC) @(negedge clk);
    `CHK(dac_code, start)
    @(negedge clk);
    `CHK(dac_code, last)
    repeat (loop_port_pkg::STEP_CYC) @(negedge clk);
    `CHK(dac_code, last)
    step_up = 0;
    step_down = 0;
  endtask : step_run
  task clear_and_ends;
    @(negedge clk) begin clear = 1; wr_lo = 1; data_in = 10'h0FF; end
    @(negedge clk) begin clear = 0; wr_lo = 0; end
    `CHK(dac_code, 10'h000)
    step_run(1'b0, 10'h001, 10'h000);
    step_run(1'b1, 10'h3FE, 10'h3FF);
    // both lines high cancel, so the top word must not step down
    @(negedge clk);
    step_up = 1;
    step_down = 1;
    repeat (loop_port_pkg::STEP_CYC + 1) @(negedge clk);
    `CHK(dac_code, 10'h3FF)
    step_up = 0;
    step_down = 0;
  endtask : clear_and_ends
  task carrier_sync;
    logic c0;
    int   k;
    c0 = carrier;
    for (k = 0; k < 70 && carrier === c0; k++) @(negedge clk);
    `CHK(carrier, ~c0)
    `CHK(synced, 1'b0)
    for (k = 0; k < 6; k++) begin
      sync_in = 1;
      repeat (4) @(negedge clk);
      `CHK(carrier, 1'b1)
      repeat (58) @(negedge clk);
      sync_in = 0;
      repeat (4) @(negedge clk);
      `CHK(carrier, 1'b0)
      repeat (58) @(negedge clk);
    end
    `CHK(synced, 1'b1)
    repeat (260) @(negedge clk);
    `CHK(synced, 1'b0)
  endtask : carrier_sync
  initial begin
    repeat (12) @(negedge clk);
    `CHK(dac_code, 10'h000)
    `CHK(data_out, 10'h000)
    rst = 0;
    split_access;
    clear_and_ends;
    carrier_sync;
    test_done;
  end
endmodule : testbench
